// File: design/sac_dev.sv
// converter end: sample hold, bit-by-bit approximation and serial readout
`timescale 1ns/100ps
`default_nettype none
module sac_dev (
    // clock and reset
    input  wire logic                         i_mclk,
    input  wire logic                         i_srst,
    // link
    sac_link_if.device                        link,
    // user side
    input  wire logic [sac_pkg::RES_BITS-1:0] i_sample,
    output logic                              o_powered,
    output logic                              o_busy,
    output logic                              o_result_valid,
    output logic [sac_pkg::RES_BITS-1:0]      o_result
);
    import sac_pkg::*;
    typedef enum logic [1:0] {ST_OFF, ST_TRACK, ST_CONV, ST_TAIL} sac_dev_state_t;
    sac_dev_state_t    state;
    logic              cs_m, cs_s, cs_d;   // select synchroniser and history
    logic              ck_m, ck_s, ck_d;   // sclk synchroniser and history
    logic              pd_m, pd_s;         // shutdown synchroniser
    logic [EDGE_W-1:0] edges;              // sclk rises since select fell
    logic [RES_BITS-1:0] held;             // held sample
    logic [RES_BITS-1:0] sar;              // approximation register
    ////////////////////////////////////////////////////////////////////////
    // decode
    wire               cs_fall    = cs_d & ~cs_s;
    wire               cs_rise    = ~cs_d & cs_s;
    wire               ck_rise    = ~ck_d & ck_s;
    wire [EDGE_W-1:0]  next_edges = edges + 1'b1;
    wire               in_bits    = next_edges >= EDGE_W'(FIRST_BIT_EDGE);
    wire [EDGE_W-1:0]  idx_w      = EDGE_W'(LAST_BIT_EDGE) - next_edges;
    wire [3:0]         bit_idx    = idx_w[3:0];
    wire [RES_BITS-1:0] trial     = sar | (RES_BITS'(1) << bit_idx);
    // keep the trial bit when its weight does not pass the sample
    wire               bit_keep   = trial <= held;  // RQ18
    wire               last_bit   = idx_w == '0;
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: link pins come from another domain
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            {cs_m, cs_s, cs_d} <= 3'h7;
            {ck_m, ck_s, ck_d} <= 3'h0;
            {pd_m, pd_s}       <= 2'h0;
        end else begin
            {cs_m, cs_s, cs_d} <= {link.cs_n, cs_m, cs_s};
            {ck_m, ck_s, ck_d} <= {link.sclk, ck_m, ck_s};
            {pd_m, pd_s}       <= {link.power_down_n, pd_m};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // conversion and readout
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state          <= ST_OFF;
            edges          <= '0;
            held           <= '0;
            sar            <= '0;
            link.dout      <= 1'b0;
            link.dout_oe   <= 1'b0;
            o_result_valid <= 1'b0;
            o_result       <= '0;
        end else begin
            o_result_valid <= 1'b0;
            if (!pd_s) begin
                // powered down: no conversion, line released
                state        <= ST_OFF;  // RQ19
                link.dout_oe <= 1'b0;
            end else begin
                case (state)
                    ST_OFF: begin
                        state <= ST_TRACK;
                    end
                    ST_TRACK: begin
                        // sclk ignored while select is high
                        if (cs_fall) begin  // RQ21
                            held         <= i_sample;  // RQ2
                            sar          <= '0;
                            edges        <= '0;
                            link.dout    <= 1'b0;      // RQ4
                            link.dout_oe <= 1'b1;      // RQ4
                            state        <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        if (cs_rise) begin
                            // abort: back to tracking, line released
                            link.dout_oe <= 1'b0;      // RQ20
                            state        <= ST_TRACK;  // RQ22
                        end else if (ck_rise) begin
                            edges <= next_edges;       // RQ5
                            if (in_bits) begin
                                sar[bit_idx] <= bit_keep;  // RQ5
                                link.dout    <= bit_keep;  // RQ6 RQ14
                                if (last_bit) begin
                                    state          <= ST_TAIL;
                                    o_result_valid <= 1'b1;
                                    o_result       <= trial & {RES_BITS{bit_keep}} | sar;
                                end
                            end else begin
                                link.dout <= 1'b0;     // RQ6
                            end
                        end
                    end
                    ST_TAIL: begin
                        if (cs_rise) begin
                            link.dout_oe <= 1'b0;      // RQ20
                            state        <= ST_TRACK;  // RQ22
                        end else if (ck_rise) begin
                            link.dout <= 1'b0;         // RQ8 RQ15
                        end
                    end
                    default: begin
                        state <= ST_OFF;
                    end
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // status outputs
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_powered <= 1'b0;
            o_busy    <= 1'b0;
        end else begin
            o_powered <= pd_s;
            o_busy    <= state == ST_CONV;
        end
    end
endmodule // sac_dev
`default_nettype wire

// File: design/sac_fifo.sv
// result buffer with registered output stage
`timescale 1ns/100ps
`default_nettype none
module sac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_srst,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW-1:0]    wp;           // write pointer
    logic [AW-1:0]    rp;           // read pointer
    logic [AW:0]      count;        // words in storage
    wire push = i_valid & o_ready;
    wire load = (count != '0) & (~o_valid | i_ready);  // refill output stage
    assign o_ready = count < (AW+1)'(DEPTH);
    ////////////////////////////////////////////////////////////////////////
    // storage write
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wp] <= i_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pointers and output stage
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            wp      <= '0;
            rp      <= '0;
            count   <= '0;
            o_valid <= 1'b0;
            o_data  <= '0;
        end else begin
            wp    <= push ? wp + 1'b1 : wp;
            rp    <= load ? rp + 1'b1 : rp;
            count <= count + (AW+1)'(push) - (AW+1)'(load);
            if (load) begin
                o_data  <= mem[rp];
                o_valid <= 1'b1;
            end else if (i_ready) begin
                o_valid <= 1'b0;
            end
        end
    end
endmodule // sac_fifo
`default_nettype wire

// File: design/sac_host.sv
// host end: power sequencing, select and sclk generation, result capture
// Notes on behaviour
// RQ1 - wait power-up time before first conversion
// RQ2 - select fall holds sample, starts conversion
// RQ3 - wait wake-up time after leaving shutdown
// RQ4 - select fall drives result line low
// RQ5 - conversion advances on serial clock
// RQ6 - two zeros, then msb first
// RQ7 - host gives at least fifteen rises
// RQ8 - extra clocks shift zeros, harmless
// RQ9 - raise select only after fifteenth rise
// RQ10 - select stays low through whole readout
// RQ11 - select high for least time between frames
// RQ12 - after abort wait acquisition time
// RQ13 - select low with sclk low first
// RQ14 - data changes on rise, host captures rise
// RQ15 - two bytes: 3 zeros+5 bits, 7 bits+zero
// RQ16 - continuous mode: fifteen clocks, phase one
// RQ17 - sclk no faster than the rated rate
// RQ18 - straight binary result, midpoint transitions
// RQ19 - shutdown low: powered down, no conversions
// RQ20 - select high: result line released
// RQ21 - sclk ignored while select high
// RQ22 - select rise ends readout, back to tracking
`timescale 1ns/100ps
`default_nettype none
module sac_host #(
    parameter int PWRUP_CYCLES = sac_pkg::PWRUP_CYC,  // power-up wait
    parameter int WAKE_CYCLES  = sac_pkg::WAKE_CYC,   // wake-up wait
    parameter int DEPTH        = sac_pkg::FIFO_DEPTH  // result buffer depth
) (
    // clock and reset
    input  wire logic                         i_mclk,
    input  wire logic                         i_srst,
    // link
    sac_link_if.host                          link,
    // control
    input  wire logic                         i_start,
    input  wire sac_pkg::sac_frame_t          i_frame,
    input  wire logic                         i_abort,
    input  wire logic                         i_shutdown,
    // status
    output logic                              o_busy,
    output logic                              o_aborted,
    // results
    output logic                              o_valid,
    input  wire logic                         i_ready,
    output logic [sac_pkg::RES_BITS-1:0]      o_data
);
    import sac_pkg::*;
    typedef enum logic [2:0] {
        H_PWRUP, H_OFF, H_IDLE, H_SETUP, H_CLK, H_DONE, H_GAP
    } sac_host_state_t;
    sac_host_state_t   state;
    sac_frame_t        frame;     // framing of the frame in flight
    logic [WAIT_W-1:0] wcnt;      // wait countdown
    logic [DIV_W-1:0]  div;       // sclk half-period divider
    logic [EDGE_W-1:0] rises;     // sclk rises given this frame
    logic [15:0]       sr;        // captured bits, first at the top
    logic              dq_m;      // result line synchroniser
    logic              dq_s;
    logic              push;      // result handed to the buffer
    logic              fifo_room; // buffer can take one more result
    ////////////////////////////////////////////////////////////////////////
    // decode
    wire               wait_done = wcnt == '0;
    wire               tick      = div == DIV_W'(SCLK_HALF_CYC - 1);  // RQ17
    wire               going_up  = tick & ~link.sclk;
    wire               going_dn  = tick & link.sclk;
    wire               cont      = frame == SAC_FRAME_CONT;
    wire [EDGE_W-1:0]  nclk      = cont ? EDGE_W'(CLKS_CONT) : EDGE_W'(CLKS_BYTES);
    // capture on rise for phase zero, on fall for phase one
    wire               capture   = (state == H_CLK) & (cont ? going_dn : going_up);  // RQ14 RQ16
    wire               last_fall = going_dn & (rises == nclk);
    wire [RES_BITS-1:0] result   = sr[RES_HI:RES_LO];  // RQ15
    wire               start_ok  = i_start & fifo_room & ~i_shutdown;
    ////////////////////////////////////////////////////////////////////////
    // result line synchroniser
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            dq_m <= 1'b0;
            dq_s <= 1'b0;
        end else begin
            dq_m <= link.dout_line;
            dq_s <= dq_m;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // sclk divider, runs only while clocking a frame
    always_ff @(posedge i_mclk) begin
        if (i_srst || !(state == H_SETUP || state == H_CLK) || tick) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // bit capture; both framings put the result in the same field
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sr <= '0;
        end else if (state == H_SETUP) begin
            sr <= '0;
        end else if (capture) begin
            sr <= {sr[14:0], dq_s};  // RQ15 RQ16
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state             <= H_PWRUP;
            wcnt              <= WAIT_W'(PWRUP_CYCLES - 1);  // RQ1
            frame             <= SAC_FRAME_BYTES;
            rises             <= '0;
            link.cs_n         <= 1'b1;
            link.sclk         <= 1'b0;
            link.power_down_n <= 1'b1;
            push              <= 1'b0;
            o_aborted         <= 1'b0;
        end else begin
            push <= 1'b0;
            case (state)
                H_PWRUP: begin
                    // reference still charging: no conversion yet
                    if (i_shutdown) begin
                        link.power_down_n <= 1'b0;
                        state             <= H_OFF;
                    end else if (wait_done) begin
                        state <= H_IDLE;   // RQ1 RQ3
                    end else begin
                        wcnt <= wcnt - 1'b1;
                    end
                end
                H_OFF: begin
                    // converter off; select stays high throughout
                    if (!i_shutdown) begin
                        link.power_down_n <= 1'b1;
                        wcnt              <= WAIT_W'(WAKE_CYCLES - 1);  // RQ3
                        state             <= H_PWRUP;
                    end
                end
                H_IDLE: begin
                    if (i_shutdown) begin
                        link.power_down_n <= 1'b0;
                        state             <= H_OFF;
                    end else if (start_ok) begin
                        // select falls with sclk parked low
                        link.cs_n <= 1'b0;  // RQ13
                        link.sclk <= 1'b0;  // RQ13
                        frame     <= i_frame;
                        rises     <= '0;
                        o_aborted <= 1'b0;
                        state     <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    // half a period here and another half in H_CLK before the first rise
                    if (tick) begin
                        state <= H_CLK;
                    end
                end
                H_CLK: begin
                    if (i_abort && !link.sclk) begin
                        // early select rise once sclk is low, so no high phase is cut short
                        link.cs_n <= 1'b1;
                        link.sclk <= 1'b0;
                        o_aborted <= 1'b1;
                        wcnt      <= WAIT_W'(ACQ_CYC - 1);  // RQ12
                        state     <= H_GAP;
                    end else if (last_fall) begin
                        // select held low until every bit is in
                        link.sclk <= 1'b0;   // RQ7 RQ10
                        link.cs_n <= 1'b1;   // RQ9
                        push      <= 1'b1;
                        wcnt      <= WAIT_W'(CSW_CYC - 1);  // RQ11
                        state     <= H_DONE;
                    end else if (tick) begin
                        link.sclk <= ~link.sclk;
                        if (going_up) begin
                            rises <= rises + 1'b1;  // RQ7
                        end
                    end
                end
                H_DONE: begin
                    wcnt  <= wcnt - 1'b1;
                    state <= H_GAP;
                end
                H_GAP: begin
                    // least select-high time before the next frame
                    if (wait_done) begin
                        state <= H_IDLE;  // RQ11 RQ12
                    end else begin
                        wcnt <= wcnt - 1'b1;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // busy flag
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_busy <= 1'b1;
        end else begin
            o_busy <= state != H_IDLE;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // result buffer; a full buffer holds off the next frame
    sac_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_valid (push),
        .o_ready (fifo_room),
        .i_data  (result),
        .o_valid (o_valid),
        .i_ready (i_ready),
        .o_data  (o_data)
    );
endmodule // sac_host
`default_nettype wire

// File: design/sac_link_if.sv
// three-wire link plus shutdown line between host and converter
`timescale 1ns/100ps
`default_nettype none
interface sac_link_if;
    logic cs_n;          // active-low select, host driven
    logic sclk;          // serial clock, host driven
    logic power_down_n;  // active-low shutdown, host driven
    logic dout;          // result bit, device driven
    logic dout_oe;       // device drives dout while high
    wire  dout_line;     // resolved wire level
    // released line shows the inverse of the last bit, so a sample taken too early is caught
    assign dout_line = dout_oe ? dout : ~dout;
    modport device (input cs_n, input sclk, input power_down_n, output dout, output dout_oe);
    modport host (output cs_n, output sclk, output power_down_n, input dout_line);
endinterface
`default_nettype wire

// File: design/sac_pkg.sv
// shared constants and types for the serial converter link and its two ends
package sac_pkg;
    ////////////////////////////////////////////////////////////////////////
    // result format
    localparam int RES_BITS       = 12;  // result width
    localparam int FIRST_BIT_EDGE = 3;   // sclk rise that shows the msb
    localparam int LAST_BIT_EDGE  = 14;  // sclk rise that shows the lsb
    localparam int CLKS_BYTES     = 16;  // clocks in two-byte framing
    localparam int CLKS_CONT      = 15;  // clocks in one continuous transfer
    localparam int EDGE_W         = 5;   // width of edge counters
    localparam int RES_HI         = 12;  // top result bit in host shifter
    localparam int RES_LO         = 1;   // lowest result bit in host shifter
    ////////////////////////////////////////////////////////////////////////
    // timing, times converted to i_mclk cycles at 125 MHz
    localparam int CLK_MHZ       = 125;
    localparam int T_PWRUP_US    = 2000;  // reference charge after power-up
    localparam int T_WAKE_US     = 2000;  // longest wake-up after shutdown
    localparam int PWRUP_CYC     = T_PWRUP_US * CLK_MHZ;
    localparam int WAKE_CYC      = T_WAKE_US * CLK_MHZ;
    localparam int T_CSW_NS      = 100;   // least select-high time
    localparam int CSW_CYC       = (T_CSW_NS * CLK_MHZ + 999) / 1000;
    localparam int T_ACQ_NS      = 625;   // least acquisition time
    localparam int ACQ_CYC       = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int F_SCLK_KHZ    = 6400;  // highest serial clock rate
    localparam int SCLK_HALF_CYC = (CLK_MHZ * 1000 + 2 * F_SCLK_KHZ - 1) / (2 * F_SCLK_KHZ);
    localparam int WAIT_W        = 18;    // wait counter width
    localparam int DIV_W         = 8;     // sclk divider width
    localparam int FIFO_DEPTH    = 32;    // result buffer depth
    ////////////////////////////////////////////////////////////////////////
    // host framing choice
    typedef enum logic {
        SAC_FRAME_BYTES,  // mode 0/0, two bytes, capture on rise
        SAC_FRAME_CONT    // mode 0/1, fifteen clocks, capture on fall
    } sac_frame_t;
endpackage

// File: tb/sac_link_checker.sv
// assertions on the wires between host and converter
`timescale 1ns/100ps
`default_nettype none
module sac_link_checker (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_srst,
    // link wires
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic power_down_n,
    input  wire logic dout,
    input  wire logic dout_oe
);
    logic [4:0] n_rise;  // sclk rises seen in this frame
    logic       sclk_q;  // sclk one cycle back
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////
    // rise counter, cleared while deselected; saturates so long frames cannot wrap
    always_ff @(posedge i_mclk) begin
        sclk_q <= sclk;
        if (i_srst || cs_n) n_rise <= 5'h00;
        else if (sclk && !sclk_q && n_rise != 5'h1F) n_rise <= n_rise + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_release; cs_n [*5] |-> !dout_oe; endproperty
    a_release: assert property (p_release) else $error("line driven while deselected");
    property p_start_low; $fell(cs_n) && power_down_n |-> ##[2:5] (dout_oe && !dout); endproperty
    a_start_low: assert property (p_start_low) else $error("line not driven low after select");
    property p_lead_zero; !cs_n && dout_oe && n_rise <= 5'h02 |-> !dout; endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
    property p_trail_zero; $rose(sclk) && n_rise >= 5'h0E |-> ##5 (!dout_oe || !dout); endproperty
    a_trail_zero: assert property (p_trail_zero) else $error("trailing bit not zero");
    // the converter moves its data three cycles after the sampled sclk rise
    property p_change_rise; $past(dout_oe) && dout_oe && $changed(dout) |-> $past(sclk, 3) && !$past(sclk, 4);
    endproperty
    a_change_rise: assert property (p_change_rise) else $error("data moved outside clock high");
    property p_setup; $fell(cs_n) |-> (!sclk) [*8]; endproperty
    a_setup: assert property (p_setup) else $error("clock not low at select");
    property p_half; $rose(sclk) |-> sclk [*8]; endproperty
    a_half: assert property (p_half) else $error("clock high phase too short");
    property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
    a_gap: assert property (p_gap) else $error("select high time too short");
    property p_off; (!power_down_n) [*8] |-> !dout_oe; endproperty
    a_off: assert property (p_off) else $error("line driven in shutdown");
endmodule // sac_link_checker
`default_nettype wire

// File: tb/test_serial_adc_conversion_readout.sv
// bench joining host and converter ends over the link
`timescale 1ns/100ps
`default_nettype none
module test_serial_adc_conversion_readout;
    import sac_pkg::*;
    logic        i_mclk     = 1'b0;             // system clock
    logic        i_srst     = 1'b1;             // sync reset
    logic [11:0] i_sample   = 12'h000;          // value the converter sees
    logic        i_start    = 1'b0;             // host frame request
    sac_frame_t  i_frame    = SAC_FRAME_BYTES;  // host framing
    logic        i_abort    = 1'b0;             // host abort
    logic        i_shutdown = 1'b0;             // host shutdown
    logic        i_ready    = 1'b1;             // result drain
    logic        o_aborted, o_valid, dev_powered, dev_valid, dev_busy, host_busy;
    logic [11:0] o_data, dev_result;
    logic [11:0] pat [5] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801, 12'h3E7};  // edge codes
    int          n_fail     = 0;
    int          num_checks = 0;
    int          n_cyc      = 0;
    int          n_conv     = 0;
    sac_link_if link ();
    sac_dev u_sac_dev (.i_mclk(i_mclk), .i_srst(i_srst), .link(link.device), .i_sample(i_sample),
        .o_powered(dev_powered), .o_busy(dev_busy), .o_result_valid(dev_valid), .o_result(dev_result));
    sac_host #(.PWRUP_CYCLES(50), .WAKE_CYCLES(50), .DEPTH(FIFO_DEPTH)) u_sac_host (.i_mclk(i_mclk),
        .i_srst(i_srst), .link(link.host), .i_start(i_start), .i_frame(i_frame), .i_abort(i_abort),
        .i_shutdown(i_shutdown), .o_busy(host_busy), .o_aborted(o_aborted), .o_valid(o_valid), .i_ready(i_ready),
        .o_data(o_data));
    sac_link_checker u_sac_link_checker (.i_mclk(i_mclk), .i_srst(i_srst), .cs_n(link.cs_n), .sclk(link.sclk),
        .power_down_n(link.power_down_n), .dout(link.dout), .dout_oe(link.dout_oe));
    initial begin
        forever #4 i_mclk = ~i_mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // compare and wait helpers; waits are bounded so a hang still reaches the verdict
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {11'h000, exp}, {11'h000, got});
    endtask
    task automatic wait_sel(input logic lvl);
        for (int k = 0; k < 2000 && link.cs_n !== lvl; k++) @(posedge i_mclk);
    endtask
    task automatic take(input logic [11:0] exp);
        for (int k = 0; k < 2000 && o_valid !== 1'b1; k++) @(posedge i_mclk);
        chk("data", exp, o_data);
        @(posedge i_mclk);
    endtask
    task automatic convert(input sac_frame_t f, input logic [11:0] v);
        i_sample <= v;
        i_frame <= f;
        i_start <= 1'b1;
        wait_sel(1'b0);
        i_start <= 1'b0;
        take(v);
        chk("device", v, dev_result);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge i_mclk) if (dev_valid === 1'b1) n_conv++;
    // cycle ceiling well above the roughly 16000 cycles the sequence needs
    always @(posedge i_mclk) begin
        n_cyc++;
        if (n_cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_mclk);
        i_srst <= 1'b0;
        i_start <= 1'b1;
        repeat (30) @(posedge i_mclk);
        chk_bit("powerup select", 1'b1, link.cs_n);
        chk_bit("powerup busy", 1'b1, host_busy);
        for (int m = 0; m < 10; m++) convert(sac_frame_t'(m % 2), pat[m / 2]);
        // abort mid-readout, then a clean frame must follow
        i_sample <= 12'h5A5;
        i_start <= 1'b1;
        wait_sel(1'b0);
        i_start <= 1'b0;
        repeat (100) @(posedge i_mclk);
        i_abort <= 1'b1;
        for (int k = 0; k < 40 && o_aborted !== 1'b1; k++) @(posedge i_mclk);
        i_abort <= 1'b0;
        repeat (5) @(posedge i_mclk);
        chk_bit("aborted", 1'b1, o_aborted);
        chk_bit("abort device busy", 1'b0, dev_busy);
        chk_bit("abort select", 1'b1, link.cs_n);
        chk_bit("abort word", 1'b0, o_valid);
        convert(SAC_FRAME_BYTES, 12'h5A5);
        // shutdown refuses frames; wake wait comes before the next one
        i_shutdown <= 1'b1;
        @(posedge i_mclk);
        i_start <= 1'b1;
        repeat (100) @(posedge i_mclk);
        chk_bit("shutdown pin", 1'b0, link.power_down_n);
        chk_bit("powered", 1'b0, dev_powered);
        chk_bit("shutdown select", 1'b1, link.cs_n);
        i_shutdown <= 1'b0;
        repeat (30) @(posedge i_mclk);
        chk_bit("wake select", 1'b1, link.cs_n);
        convert(SAC_FRAME_CONT, 12'h123);
        // fill the buffer with the drain stalled, then drain in order
        i_ready <= 1'b0;
        i_start <= 1'b1;
        for (int k = 0; k < 33; k++) begin
            i_sample <= 12'h100 + 12'(k);
            wait_sel(1'b0);
            wait_sel(1'b1);
        end
        repeat (600) @(posedge i_mclk);
        chk_bit("full select", 1'b1, link.cs_n);
        i_start <= 1'b0;
        i_ready <= 1'b1;
        @(posedge i_mclk);
        for (int k = 0; k < 33; k++) take(12'h100 + 12'(k));
        chk_bit("empty", 1'b0, o_valid);
        chk("conversions", 12'h02D, 12'(n_conv));
        tally_and_finish();
    end
endmodule // test_serial_adc_conversion_readout
`default_nettype wire
